/* sca_defines.vh */
`ifndef SCA_DEFINES_VH
`define SCA_DEFINES_VH

// --------------------------------------------------------------------
// chain entry selection
// --------------------------------------------------------------------
`define SCA_ENTRY_CHAIN 1'b0
`define SCA_ENTRY_BYPASS 1'b1

// --------------------------------------------------------------------
// generate source selection
// --------------------------------------------------------------------
`define SCA_GEN_W 3
`define SCA_GEN_IN_A 3'h0
`define SCA_GEN_IN_B 3'h1
`define SCA_GEN_AND 3'h2
`define SCA_GEN_BYPASS 3'h3
`define SCA_GEN_ONE 3'h4
`define SCA_GEN_ZERO 3'h5

// --------------------------------------------------------------------
// propagate select source and sum routing
// --------------------------------------------------------------------
`define SCA_PROP_LUT 1'b0
`define SCA_PROP_ONE 1'b1
`define SCA_ROUTE_COMB 1'b0
`define SCA_ROUTE_REG 1'b1

// --------------------------------------------------------------------
// look-up table defaults and plain levels
// --------------------------------------------------------------------
`define SCA_LUT_W 16
`define SCA_LUT_XOR_AB 16'h6666
`define SCA_BIT_ZERO 1'b0
`define SCA_BIT_ONE 1'b1
`define SCA_PAIR_ZERO 2'h0
`define SCA_PAIR_ONE 2'h3

`endif

/* sca_slice.v */
// Summary of operation
// - carry enters from the slice below and leaves to the slice above
// - chain can start at any slice from the lower bypass input
// - static entry mux picks carry from below or lower bypass input
// - lower generate source: input a, input b, partial and, bypass, one, zero
// - upper generate source: input a, input b, partial and, bypass, one, zero
// - lower carry mux: entry carry when select high, generate when low
// - upper carry mux: lower carry when select high, generate when low
// - propagate select is the half's table output or constant one
// - lower sum is lower table output xor entry carry, comb or registered
// - upper sum is upper table output xor lower carry, comb or registered
// - lower partial and combines lower inputs a and b into generate
// - upper partial and combines upper inputs a and b into generate
// - slice carry out comes from the carry muxes, two bits per slice
// - flops initialise at power-up, global init, local force inputs
// - local set/reset forces per attribute; sync or async per slice
// - opposite input forces the other state; reset wins when both active
// - global init is active high unless inverted ahead of its input
`timescale 1ns/1ns
`include "sca_defines.vh"

module sca_slice #(
   // static configuration of the slice
   parameter ENTRY_SEL = `SCA_ENTRY_CHAIN,
   parameter [`SCA_GEN_W-1:0] LOWER_GEN_SEL = `SCA_GEN_IN_A,
   parameter [`SCA_GEN_W-1:0] UPPER_GEN_SEL = `SCA_GEN_IN_A,
   parameter LOWER_PROP_SEL = `SCA_PROP_LUT,
   parameter UPPER_PROP_SEL = `SCA_PROP_LUT,
   parameter LOWER_ROUTE = `SCA_ROUTE_COMB,
   parameter UPPER_ROUTE = `SCA_ROUTE_COMB,
   parameter [`SCA_LUT_W-1:0] LOWER_LUT_TABLE = `SCA_LUT_XOR_AB,
   parameter [`SCA_LUT_W-1:0] UPPER_LUT_TABLE = `SCA_LUT_XOR_AB,
   // storage attributes, bit 0 lower flop, bit 1 upper flop
   parameter [1:0] FORCE_ONE_ATTR = `SCA_PAIR_ZERO,
   parameter [1:0] START_FOLLOWS_FORCE = `SCA_PAIR_ONE,
   parameter [1:0] START_HIGH_ATTR = `SCA_PAIR_ZERO,
   parameter SET_RESET_SYNC = `SCA_BIT_ONE,
   parameter GLOBAL_INIT_INVERT = `SCA_BIT_ZERO
) (
   input wire CLK_SYS_IN,
   input wire ARST_N_IN,
   input wire CHAIN_CARRY_IN,
   input wire LOWER_BYPASS_IN,
   input wire UPPER_BYPASS_IN,
   input wire LOWER_LUT_IN_A_IN,
   input wire LOWER_LUT_IN_B_IN,
   input wire LOWER_LUT_IN_C_IN,
   input wire LOWER_LUT_IN_D_IN,
   input wire UPPER_LUT_IN_A_IN,
   input wire UPPER_LUT_IN_B_IN,
   input wire UPPER_LUT_IN_C_IN,
   input wire UPPER_LUT_IN_D_IN,
   input wire LOCAL_SET_RESET_IN,
   input wire OPPOSITE_FORCE_INPUT_IN,
   input wire GLOBAL_INIT_INPUT_IN,
   output wire LOWER_LUT_OUT,
   output wire UPPER_LUT_OUT,
   output wire LOWER_SUM_OUT,
   output wire UPPER_SUM_OUT,
   output wire LOWER_REG_OUT,
   output wire UPPER_REG_OUT,
   output wire LOWER_CARRY_OUT,
   output wire CHAIN_CARRY_OUT
);

   // --------------------------------------------------------------------
   // helper functions
   // --------------------------------------------------------------------

   // four-input table lookup, index is {d,c,b,a}
   function lut4;
      input [`SCA_LUT_W-1:0] lut_tbl;
      input a;
      input b;
      input c;
      input d;
      begin
         lut4 = lut_tbl[{d, c, b, a}];
      end
   endfunction

   // generate source decode, shared by both halves
   function gen_pick;
      input [`SCA_GEN_W-1:0] sel;
      input in_a;
      input in_b;
      input and_v;
      input bypass;
      begin
         case (sel)
            `SCA_GEN_IN_A: begin
               gen_pick = in_a;
            end
            `SCA_GEN_IN_B: begin
               gen_pick = in_b;
            end
            `SCA_GEN_AND: begin
               gen_pick = and_v;
            end
            `SCA_GEN_BYPASS: begin
               gen_pick = bypass;
            end
            `SCA_GEN_ONE: begin
               gen_pick = `SCA_BIT_ONE;
            end
            default: begin
               gen_pick = `SCA_BIT_ZERO;
            end
         endcase
      end
   endfunction

   // --------------------------------------------------------------------
   // look-up tables
   // --------------------------------------------------------------------

   wire lower_lut;
   wire upper_lut;

   // table outputs, usually the half-sums
   assign lower_lut = lut4(LOWER_LUT_TABLE, LOWER_LUT_IN_A_IN, LOWER_LUT_IN_B_IN,
                           LOWER_LUT_IN_C_IN, LOWER_LUT_IN_D_IN);
   assign upper_lut = lut4(UPPER_LUT_TABLE, UPPER_LUT_IN_A_IN, UPPER_LUT_IN_B_IN,
                           UPPER_LUT_IN_C_IN, UPPER_LUT_IN_D_IN);

   // --------------------------------------------------------------------
   // partial-product gates
   // --------------------------------------------------------------------

   wire lower_partial_and;
   wire upper_partial_and;

   // duplicate of one partial product for multipliers
   assign lower_partial_and = LOWER_LUT_IN_A_IN & LOWER_LUT_IN_B_IN;
   assign upper_partial_and = UPPER_LUT_IN_A_IN & UPPER_LUT_IN_B_IN;

   // --------------------------------------------------------------------
   // carry chain
   // --------------------------------------------------------------------

   wire chain_entry_mux;
   wire lower_generate_mux;
   wire upper_generate_mux;
   wire lower_propagate_select;
   wire upper_propagate_select;
   wire lower_carry_mux;
   wire upper_carry_mux;

   // carry start: from the slice below or a fresh start at the bypass
   assign chain_entry_mux = (ENTRY_SEL == `SCA_ENTRY_BYPASS) ?
                            LOWER_BYPASS_IN : CHAIN_CARRY_IN;

   // generate sources, fixed by configuration
   assign lower_generate_mux = gen_pick(LOWER_GEN_SEL, LOWER_LUT_IN_A_IN,
                                        LOWER_LUT_IN_B_IN, lower_partial_and,
                                        LOWER_BYPASS_IN);
   assign upper_generate_mux = gen_pick(UPPER_GEN_SEL, UPPER_LUT_IN_A_IN,
                                        UPPER_LUT_IN_B_IN, upper_partial_and,
                                        UPPER_BYPASS_IN);

   // propagate selects: table output or always propagate
   assign lower_propagate_select = (LOWER_PROP_SEL == `SCA_PROP_ONE) ?
                                   `SCA_BIT_ONE : lower_lut;
   assign upper_propagate_select = (UPPER_PROP_SEL == `SCA_PROP_ONE) ?
                                   `SCA_BIT_ONE : upper_lut;

   // dynamic carry muxes, propagate when select is high
   assign lower_carry_mux = lower_propagate_select ?
                            chain_entry_mux : lower_generate_mux;
   assign upper_carry_mux = upper_propagate_select ?
                            lower_carry_mux : upper_generate_mux;

   // carry leaves toward the slice directly above
   assign CHAIN_CARRY_OUT = upper_carry_mux;
   assign LOWER_CARRY_OUT = lower_carry_mux;

   // --------------------------------------------------------------------
   // sum gates and routing
   // --------------------------------------------------------------------

   wire lower_sum_xor;
   wire upper_sum_xor;
   wire [1:0] sum_v;
   wire [1:0] reg_v;
   wire [1:0] route_reg;

   // sums completed with the incoming carry of each half
   assign lower_sum_xor = lower_lut ^ chain_entry_mux;
   assign upper_sum_xor = upper_lut ^ lower_carry_mux;
   assign sum_v = {upper_sum_xor, lower_sum_xor};
   assign route_reg = {(UPPER_ROUTE == `SCA_ROUTE_REG), (LOWER_ROUTE == `SCA_ROUTE_REG)};

   // combinational outputs read zero when the sum is routed to the flop
   assign LOWER_SUM_OUT = route_reg[0] ? `SCA_BIT_ZERO : lower_sum_xor;
   assign UPPER_SUM_OUT = route_reg[1] ? `SCA_BIT_ZERO : upper_sum_xor;
   assign LOWER_REG_OUT = reg_v[0];
   assign UPPER_REG_OUT = reg_v[1];
   assign LOWER_LUT_OUT = lower_lut;
   assign UPPER_LUT_OUT = upper_lut;

   // --------------------------------------------------------------------
   // storage controls
   // --------------------------------------------------------------------

   wire global_init_act;
   wire force_hit;
   wire async_hit;
   wire [1:0] start_v;

   // global init polarity, inverted ahead of the input on request
   assign global_init_act = GLOBAL_INIT_INPUT_IN ^ GLOBAL_INIT_INVERT;

   // local force inputs, shared sync or async setting
   assign force_hit = LOCAL_SET_RESET_IN | OPPOSITE_FORCE_INPUT_IN;
   assign async_hit = force_hit & ~SET_RESET_SYNC;

   // start value follows the force attribute unless overridden
   assign start_v = (START_FOLLOWS_FORCE & FORCE_ONE_ATTR) |
                    (~START_FOLLOWS_FORCE & START_HIGH_ATTR);

   // --------------------------------------------------------------------
   // storage elements
   // --------------------------------------------------------------------

   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1) begin : g_flop
         reg flop_q;
         wire flop_d;

         // capture the sum only when it is routed to the flop
         assign flop_d = route_reg[i] ? sum_v[i] : flop_q;
         assign reg_v[i] = flop_q;

         // reset > local force > global init > data
         always @(posedge CLK_SYS_IN or negedge ARST_N_IN or posedge async_hit) begin
            if (!ARST_N_IN) begin
               flop_q <= START_FOLLOWS_FORCE[i] ? FORCE_ONE_ATTR[i] :
                         START_HIGH_ATTR[i];
            end else if (async_hit || force_hit) begin
               if (LOCAL_SET_RESET_IN && OPPOSITE_FORCE_INPUT_IN) begin
                  flop_q <= `SCA_BIT_ZERO;
               end else if (LOCAL_SET_RESET_IN) begin
                  flop_q <= FORCE_ONE_ATTR[i];
               end else begin
                  flop_q <= ~FORCE_ONE_ATTR[i];
               end
            end else if (global_init_act) begin
               flop_q <= start_v[i];
            end else begin
               flop_q <= flop_d;
            end
         end
      end
   endgenerate

endmodule

/* sca_slice_end.v */
`timescale 1ns/1ns

/* sca_neighbour_model.sv */
`timescale 1ns/1ns
// ------------------------------
// slice below: one-bit adder stage
// ------------------------------
module sca_neighbour_model (
   input wire logic a_in,
   input wire logic b_in,
   input wire logic c_in,
   output logic carry_out
);
   // carry handed up the column
   assign carry_out = (a_in & b_in) | (c_in & (a_in ^ b_in));
endmodule

/* sca_slice_sva.sv */
`timescale 1ns/1ns
module sca_slice_sva #(
   parameter [1:0] FORCE_ONE_ATTR = 2'h0
) (
   input wire CLK_SYS_IN,
   input wire ARST_N_IN,
   input wire CHAIN_CARRY_IN,
   input wire LOWER_LUT_IN_A_IN,
   input wire LOWER_LUT_IN_B_IN,
   input wire UPPER_BYPASS_IN,
   input wire LOCAL_SET_RESET_IN,
   input wire OPPOSITE_FORCE_INPUT_IN,
   input wire GLOBAL_INIT_INPUT_IN,
   input wire LOWER_LUT_OUT,
   input wire UPPER_LUT_OUT,
   input wire LOWER_SUM_OUT,
   input wire LOWER_REG_OUT,
   input wire UPPER_REG_OUT,
   input wire LOWER_CARRY_OUT,
   input wire CHAIN_CARRY_OUT
);
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!ARST_N_IN);
   // ------------------------------
   // control phases
   // ------------------------------
   sequence s_quiet;
      !LOCAL_SET_RESET_IN && !OPPOSITE_FORCE_INPUT_IN && !GLOBAL_INIT_INPUT_IN;
   endsequence
   sequence s_both;
      LOCAL_SET_RESET_IN && OPPOSITE_FORCE_INPUT_IN;
   endsequence
   // ------------------------------
   // carry, sum and flop checks
   // ------------------------------
   a_lower_prop_path: assert property (LOWER_LUT_OUT |-> LOWER_CARRY_OUT == CHAIN_CARRY_IN)
      else $error("lower carry not propagated");
   a_lower_gen_and: assert property (!LOWER_LUT_OUT |->
      LOWER_CARRY_OUT == (LOWER_LUT_IN_A_IN & LOWER_LUT_IN_B_IN))
      else $error("lower generate wrong");
   a_upper_prop_path: assert property (UPPER_LUT_OUT |-> CHAIN_CARRY_OUT == LOWER_CARRY_OUT)
      else $error("upper carry not propagated");
   a_upper_gen_bypass: assert property (!UPPER_LUT_OUT |-> CHAIN_CARRY_OUT == UPPER_BYPASS_IN)
      else $error("upper generate wrong");
   a_lower_sum_xor: assert property (LOWER_SUM_OUT == (LOWER_LUT_OUT ^ CHAIN_CARRY_IN))
      else $error("lower sum wrong");
   a_upper_sum_reg: assert property (s_quiet |=>
      UPPER_REG_OUT == $past(UPPER_LUT_OUT ^ LOWER_CARRY_OUT))
      else $error("upper registered sum wrong");
   a_lower_hold: assert property (s_quiet |=> $stable(LOWER_REG_OUT))
      else $error("lower flop changed");
   a_reset_wins: assert property (s_both |=> !LOWER_REG_OUT && !UPPER_REG_OUT)
      else $error("both forces not zero");
   a_local_force: assert property (LOCAL_SET_RESET_IN && !OPPOSITE_FORCE_INPUT_IN |=>
      {UPPER_REG_OUT, LOWER_REG_OUT} == FORCE_ONE_ATTR)
      else $error("local force wrong");
   a_opposite_force: assert property (!LOCAL_SET_RESET_IN && OPPOSITE_FORCE_INPUT_IN |=>
      {UPPER_REG_OUT, LOWER_REG_OUT} == ~FORCE_ONE_ATTR)
      else $error("opposite force wrong");
   a_global_start: assert property (GLOBAL_INIT_INPUT_IN && !LOCAL_SET_RESET_IN &&
      !OPPOSITE_FORCE_INPUT_IN |=> {UPPER_REG_OUT, LOWER_REG_OUT} == FORCE_ONE_ATTR)
      else $error("global init start wrong");
endmodule
bind sca_slice sca_slice_sva #(.FORCE_ONE_ATTR(FORCE_ONE_ATTR)) u_sva (
   .CLK_SYS_IN(CLK_SYS_IN), .ARST_N_IN(ARST_N_IN), .CHAIN_CARRY_IN(CHAIN_CARRY_IN),
   .LOWER_LUT_IN_A_IN(LOWER_LUT_IN_A_IN), .LOWER_LUT_IN_B_IN(LOWER_LUT_IN_B_IN),
   .UPPER_BYPASS_IN(UPPER_BYPASS_IN), .LOCAL_SET_RESET_IN(LOCAL_SET_RESET_IN),
   .OPPOSITE_FORCE_INPUT_IN(OPPOSITE_FORCE_INPUT_IN),
   .GLOBAL_INIT_INPUT_IN(GLOBAL_INIT_INPUT_IN), .LOWER_LUT_OUT(LOWER_LUT_OUT),
   .UPPER_LUT_OUT(UPPER_LUT_OUT), .LOWER_SUM_OUT(LOWER_SUM_OUT),
   .LOWER_REG_OUT(LOWER_REG_OUT), .UPPER_REG_OUT(UPPER_REG_OUT),
   .LOWER_CARRY_OUT(LOWER_CARRY_OUT), .CHAIN_CARRY_OUT(CHAIN_CARRY_OUT));

/* tb_sca_slice.sv */
`timescale 1ns/1ns
`include "sca_defines.vh"
module tb_sca_slice;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [15:0] v = 16'h0000;
   logic exp_l = 1'b0;
   logic exp_u = 1'b1;
   logic [15:0] dir [8] = '{16'h0c11, 16'h0033, 16'h0233, 16'h6000,
      16'h2000, 16'h4000, 16'h8000, 16'ha000};
   logic [31:0] r;
   wire chain_carry_in, llut, ulut, lsum, usum, lreg, ureg, lco, co;
   int err_total = 0;
   int num_checks = 0;
   // ------------------------------
   // clock, partner and design
   // ------------------------------
   initial forever #25 clk = ~clk;
   sca_neighbour_model u_below (.a_in(v[10]), .b_in(v[11]), .c_in(v[12]), .carry_out(chain_carry_in));
   sca_slice #(.LOWER_GEN_SEL(`SCA_GEN_AND), .UPPER_GEN_SEL(`SCA_GEN_BYPASS),
      .UPPER_ROUTE(`SCA_ROUTE_REG), .FORCE_ONE_ATTR(2'h2)) u_dut (
      .CLK_SYS_IN(clk), .ARST_N_IN(arst_n), .CHAIN_CARRY_IN(chain_carry_in),
      .LOWER_BYPASS_IN(v[8]), .UPPER_BYPASS_IN(v[9]),
      .LOWER_LUT_IN_A_IN(v[0]), .LOWER_LUT_IN_B_IN(v[1]), .LOWER_LUT_IN_C_IN(v[2]),
      .LOWER_LUT_IN_D_IN(v[3]), .UPPER_LUT_IN_A_IN(v[4]), .UPPER_LUT_IN_B_IN(v[5]),
      .UPPER_LUT_IN_C_IN(v[6]), .UPPER_LUT_IN_D_IN(v[7]), .LOCAL_SET_RESET_IN(v[13]),
      .OPPOSITE_FORCE_INPUT_IN(v[14]), .GLOBAL_INIT_INPUT_IN(v[15]),
      .LOWER_LUT_OUT(llut), .UPPER_LUT_OUT(ulut), .LOWER_SUM_OUT(lsum),
      .UPPER_SUM_OUT(usum), .LOWER_REG_OUT(lreg), .UPPER_REG_OUT(ureg),
      .LOWER_CARRY_OUT(lco), .CHAIN_CARRY_OUT(co));
   // ------------------------------
   // expectations and checks
   // ------------------------------
   function automatic logic f_cin(input logic [15:0] x);
      return (x[10] & x[11]) | (x[12] & (x[10] ^ x[11]));
   endfunction
   function automatic logic f_lco(input logic [15:0] x);
      return (x[0] ^ x[1]) ? f_cin(x) : (x[0] & x[1]);
   endfunction
   function automatic logic f_co(input logic [15:0] x);
      return (x[4] ^ x[5]) ? f_lco(x) : x[9];
   endfunction
   task automatic check(input logic seen, input logic want);
      num_checks++;
      if (seen !== want) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen %b want %b", $time, seen, want);
      end
   endtask
   task automatic check_all;
      check(chain_carry_in, f_cin(v));
      check(llut, v[0] ^ v[1]);
      check(lsum, v[0] ^ v[1] ^ f_cin(v));
      check(lco, f_lco(v));
      check(co, f_co(v));
      check(usum, 1'b0);
      check(lreg, exp_l);
      check(ureg, exp_u);
   endtask
   // flop model at the edge, then new stimulus
   task automatic step(input logic [15:0] nv);
      @(posedge clk);
      if (v[13] | v[14]) begin
         exp_l = v[14] & !v[13];
         exp_u = v[13] & !v[14];
      end else if (v[15]) begin
         exp_l = 1'b0;
         exp_u = 1'b1;
      end else begin
         exp_u = v[4] ^ v[5] ^ f_lco(v);
      end
      #5 v = nv;
      #1 check_all;
   endtask
   task automatic conclude;
      $display("errors %0d checks %0d", err_total, num_checks);
      if (err_total == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ------------------------------
   // main sequence and watchdog
   // ------------------------------
   initial begin
      #30000 err_total++;
      conclude();
   end
   initial begin
      r = $urandom(57785);
      repeat (20) @(posedge clk);
      #5 arst_n = 1'b1;
      #1 check_all;
      for (int i = 0; i < 8; i++) step(dir[i]);
      for (int i = 0; i < 300; i++) begin
         r = $urandom;
         if (r[19:17] != 3'h0) r[15:13] = 3'h0;
         step(r[15:0]);
      end
      @(posedge clk);
      #5 arst_n = 1'b0;
      exp_l = 1'b0;
      exp_u = 1'b1;
      #1 check_all;
      @(posedge clk);
      #5 arst_n = 1'b1;
      v = 16'h0000;
      step(16'h0011);
      step(16'h0000);
      conclude();
   end
endmodule
